/* verilog/afc_pkg.sv */
// Package for the analog front-end control block.
// Assumes a single 100 MHz core clock and an active-low asynchronous reset.
package afc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DAC_W = 8;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned CTRL_W = 8;
  // Positions of the control bits in the first analog control register.
  localparam int unsigned REG_ON_POS = 1;
  localparam int unsigned BIAS_EN_POS = 3;
  localparam int unsigned SRC_EN_POS = 4;
  localparam int unsigned PULLDN_POS = 5;
  localparam int unsigned DAC_ROUTE_POS = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic [DAC_W-1:0] DAC_RST = 8'h00;
  // Comparator input selections.
  localparam logic [SEL_W-1:0] SEL_IN_X = 3'h0;
  localparam logic [SEL_W-1:0] SEL_IN_Y = 3'h1;
  localparam logic [SEL_W-1:0] SEL_IN_Z = 3'h2;
  typedef enum logic [1:0] {
    AFC_RUN = 2'b00,
    AFC_IDLE = 2'b01
  } afc_mode_t;
endpackage : afc_pkg

/* verilog/afc_clk_if.sv */
// Interface between the clock divider and the control core.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface afc_clk_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : afc_clk_if

/* verilog/afc_clk_div.sv */
// Divide-by-two stage for the oscillator input.
// Assumes the oscillator input is already synchronised to clock_i.
`timescale 1ns/1ps
module afc_clk_div (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Oscillator level and divided tick
  input wire logic osc_i,
  afc_clk_if.src tick_if
);
  logic osc_d_r, osc_d_nxt;
  logic half_r, half_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    osc_d_nxt = osc_i;
    half_nxt = half_r;
    tick_nxt = 1'b0;
    if (osc_i && !osc_d_r) begin
      half_nxt = ~half_r;
      tick_nxt = half_r;
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_d_r <= 1'b0;
      half_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      osc_d_r <= osc_d_nxt;
      half_r <= half_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick_if.tick = tick_r;
  // The tick marks every second rising edge of the oscillator.
  div_two_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE12
    tick_r |-> $past(half_r) && $past(osc_i) && !$past(osc_d_r))
    else $error("divided tick without a second oscillator rising edge");
endmodule : afc_clk_div

/* verilog/afc_top.sv */
// Control core of the analog section with idle-mode handling.
// Assumes control fields come from processor logic on clock_i; pins are asynchronous.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Regulator on bit switches the regulator that feeds supply pin and DAC.
// RULE2: Bias and source enable bits connect regulator output to their pins.
// RULE3: The 8-bit DAC code always drives the fixed DAC output.
// RULE4: Switched DAC output carries the DAC only while the route bit is set.
// RULE5: Three-bit select picks one of three comparator inputs; bandgap on negative.
// RULE6: Comparator output may trigger capture on counter module four.
// RULE7: Pulldown bit enables the low-impedance ramp pulldown.
// RULE8: Idle stops the processor; timers and interrupts run; DAC is disabled.
// RULE9: Processor state, RAM and registers are kept through idle.
// RULE10: Enabled interrupt or hardware reset ends idle.
// RULE11: Firmware waits for analog references to settle before DAC conversions.
// RULE12: Oscillator input passes a divide-by-two stage before internal clocks.
// RULE13: All analog control bits and the select field clear on reset.
module afc_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Oscillator pin
  input wire logic crystal_input_i,
  // Register writes from the processor
  input wire logic ctrl_first_we_i,
  input wire logic [afc_pkg::CTRL_W-1:0] ctrl_first_wdata_i,
  input wire logic ctrl_second_we_i,
  input wire logic [afc_pkg::SEL_W-1:0] ctrl_second_wdata_i,
  input wire logic dac_we_i,
  input wire logic [afc_pkg::DAC_W-1:0] dac_wdata_i,
  // Power control
  input wire logic idle_req_i,
  input wire logic irq_pending_i,
  // Comparator
  input wire logic comp_raw_i,
  input wire logic capture_sel_i,
  // Analog switch controls
  output logic regulator_on_o,
  output logic bias_supply_pin_en_o,
  output logic source_supply_pin_en_o,
  output logic ramp_pulldown_pin_en_o,
  output logic [afc_pkg::DAC_W-1:0] fixed_dac_output_pin_o,
  output logic switched_dac_output_pin_en_o,
  output logic dac_enable_o,
  output logic [afc_pkg::SEL_W-1:0] comparator_input_select_o,
  // Core status
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic idle_o,
  output logic irq_wake_o,
  output logic capture_trig_o,
  output logic [afc_pkg::CTRL_W-1:0] analog_control_first_o,
  output logic [afc_pkg::SEL_W-1:0] analog_control_second_o
);
  afc_clk_if tick_if ();
  logic osc_s1_r, osc_s2_r;
  logic comp_s1_r, comp_s2_r;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
    end else begin
      osc_s1_r <= crystal_input_i;
      osc_s2_r <= osc_s1_r;
      comp_s1_r <= comp_raw_i;
      comp_s2_r <= comp_s1_r;
    end
  end

  afc_clk_div u_div (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .osc_i(osc_s2_r),
    .tick_if(tick_if.src)
  );

  logic [afc_pkg::CTRL_W-1:0] ctrl_first_r, ctrl_first_nxt;
  logic [afc_pkg::SEL_W-1:0] ctrl_second_r, ctrl_second_nxt;
  logic [afc_pkg::DAC_W-1:0] dac_r, dac_nxt;
  afc_pkg::afc_mode_t mode_r, mode_nxt;
  logic cpu_en_r, cpu_en_nxt;
  logic per_en_r, per_en_nxt;
  logic wake_r, wake_nxt;
  logic cap_r, cap_nxt;
  logic tick;
  assign tick = tick_if.tick;

  always_comb begin
    ctrl_first_nxt = ctrl_first_r;
    ctrl_second_nxt = ctrl_second_r;
    dac_nxt = dac_r;
    mode_nxt = mode_r;
    wake_nxt = 1'b0;
    // Writes are only accepted while the processor runs; idle keeps every register.
    if (mode_r == afc_pkg::AFC_RUN) begin // RULE9
      if (ctrl_first_we_i) begin
        ctrl_first_nxt = ctrl_first_wdata_i;
      end
      if (ctrl_second_we_i) begin
        ctrl_second_nxt = ctrl_second_wdata_i;
      end
      if (dac_we_i) begin
        dac_nxt = dac_wdata_i;
      end
    end
    case (mode_r)
      afc_pkg::AFC_RUN: begin
        if (idle_req_i && !irq_pending_i) begin
          mode_nxt = afc_pkg::AFC_IDLE; // RULE8
        end
      end
      afc_pkg::AFC_IDLE: begin
        if (irq_pending_i) begin
          mode_nxt = afc_pkg::AFC_RUN; // RULE10
          wake_nxt = 1'b1;
        end
      end
      default: begin
        mode_nxt = afc_pkg::AFC_RUN;
      end
    endcase
    cpu_en_nxt = tick && (mode_nxt == afc_pkg::AFC_RUN); // RULE8 RULE12
    per_en_nxt = tick; // RULE12
    cap_nxt = capture_sel_i && comp_s2_r && per_en_r; // RULE6
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_first_r <= afc_pkg::CTRL_RST; // RULE13
      ctrl_second_r <= afc_pkg::SEL_RST; // RULE13
      dac_r <= afc_pkg::DAC_RST;
      mode_r <= afc_pkg::AFC_RUN; // RULE10
      cpu_en_r <= 1'b0;
      per_en_r <= 1'b0;
      wake_r <= 1'b0;
      cap_r <= 1'b0;
    end else begin
      ctrl_first_r <= ctrl_first_nxt;
      ctrl_second_r <= ctrl_second_nxt;
      dac_r <= dac_nxt;
      mode_r <= mode_nxt;
      cpu_en_r <= cpu_en_nxt;
      per_en_r <= per_en_nxt;
      wake_r <= wake_nxt;
      cap_r <= cap_nxt;
    end
  end

  // Output registers, one cycle behind the control state.
  logic reg_on_r, bias_r, src_r, pd_r, route_r, dac_en_r;
  logic [afc_pkg::DAC_W-1:0] dac_out_r;
  logic [afc_pkg::SEL_W-1:0] sel_out_r;
  logic idle_r;
  logic reg_on_nxt, bias_nxt, src_nxt, pd_nxt, route_nxt, dac_en_nxt;
  logic [afc_pkg::DAC_W-1:0] dac_out_nxt;
  logic [afc_pkg::SEL_W-1:0] sel_out_nxt;
  logic idle_nxt;
  always_comb begin
    reg_on_nxt = ctrl_first_r[afc_pkg::REG_ON_POS]; // RULE1
    bias_nxt = reg_on_nxt && ctrl_first_r[afc_pkg::BIAS_EN_POS]; // RULE2
    src_nxt = reg_on_nxt && ctrl_first_r[afc_pkg::SRC_EN_POS]; // RULE2
    pd_nxt = ctrl_first_r[afc_pkg::PULLDN_POS]; // RULE7
    idle_nxt = (mode_r == afc_pkg::AFC_IDLE);
    dac_en_nxt = reg_on_nxt && !idle_nxt; // RULE1 RULE8
    route_nxt = ctrl_first_r[afc_pkg::DAC_ROUTE_POS] && dac_en_nxt; // RULE4
    dac_out_nxt = dac_r; // RULE3
    // Only the three documented selections are passed; others fall back to the first input.
    case (ctrl_second_r)
      afc_pkg::SEL_IN_X, afc_pkg::SEL_IN_Y, afc_pkg::SEL_IN_Z: begin
        sel_out_nxt = ctrl_second_r; // RULE5
      end
      default: begin
        sel_out_nxt = afc_pkg::SEL_IN_X;
      end
    endcase
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_on_r <= 1'b0;
      bias_r <= 1'b0;
      src_r <= 1'b0;
      pd_r <= 1'b0;
      route_r <= 1'b0;
      dac_en_r <= 1'b0;
      dac_out_r <= afc_pkg::DAC_RST;
      sel_out_r <= afc_pkg::SEL_RST;
      idle_r <= 1'b0;
    end else begin
      reg_on_r <= reg_on_nxt;
      bias_r <= bias_nxt;
      src_r <= src_nxt;
      pd_r <= pd_nxt;
      route_r <= route_nxt;
      dac_en_r <= dac_en_nxt;
      dac_out_r <= dac_out_nxt;
      sel_out_r <= sel_out_nxt;
      idle_r <= idle_nxt;
    end
  end

  assign regulator_on_o = reg_on_r;
  assign bias_supply_pin_en_o = bias_r;
  assign source_supply_pin_en_o = src_r;
  assign ramp_pulldown_pin_en_o = pd_r;
  assign switched_dac_output_pin_en_o = route_r;
  assign dac_enable_o = dac_en_r;
  assign fixed_dac_output_pin_o = dac_out_r;
  assign comparator_input_select_o = sel_out_r;
  assign cpu_clk_en_o = cpu_en_r;
  assign periph_clk_en_o = per_en_r;
  assign idle_o = idle_r;
  assign irq_wake_o = wake_r;
  assign capture_trig_o = cap_r;
  assign analog_control_first_o = ctrl_first_r;
  assign analog_control_second_o = ctrl_second_r;

  sequence idle_entry_s;
    mode_r == afc_pkg::AFC_RUN && idle_req_i && !irq_pending_i;
  endsequence
  sequence idle_exit_s;
    mode_r == afc_pkg::AFC_IDLE && irq_pending_i;
  endsequence
  reg_switch_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE1
    1'b1 |=> regulator_on_o == $past(ctrl_first_r[afc_pkg::REG_ON_POS])) else $error("regulator mismatch");
  bias_gate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE2
    (bias_supply_pin_en_o || source_supply_pin_en_o) |-> regulator_on_o) else $error("bias pin without regulator");
  dac_follow_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE3
    dac_we_i && mode_r == afc_pkg::AFC_RUN |=> ##1 fixed_dac_output_pin_o == $past(dac_wdata_i, 2))
    else $error("fixed DAC output stale");
  route_gate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE4
    switched_dac_output_pin_en_o |-> $past(ctrl_first_r[afc_pkg::DAC_ROUTE_POS]))
    else $error("DAC routed without bit");
  sel_valid_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE5
    comparator_input_select_o <= afc_pkg::SEL_IN_Z) else $error("bad comparator select");
  capture_src_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE6
    capture_trig_o |-> $past(capture_sel_i) && $past(comp_s2_r)) else $error("capture without comparator");
  pulldown_map_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE7
    1'b1 |=> ramp_pulldown_pin_en_o == $past(ctrl_first_r[afc_pkg::PULLDN_POS]))
    else $error("pulldown mismatch");
  idle_stop_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE8
    idle_entry_s |=> ##1 idle_o && !dac_enable_o) else $error("idle did not stop DAC");
  idle_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE9
    mode_r == afc_pkg::AFC_IDLE |=> $stable(ctrl_first_r) && $stable(ctrl_second_r) && $stable(dac_r))
    else $error("register changed in idle");
  idle_wake_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE10
    idle_exit_s |=> irq_wake_o ##1 !idle_o) else $error("interrupt did not end idle");
endmodule : afc_top

/* tb/afc_sense_model.sv */
// Far-side model: external clock source and comparator on the selected input.
// Assumes the bench supplies the three analog input levels as logic levels.
`timescale 1ns/1ps
module afc_sense_model (
  // Clock
  input wire logic clock_i,
  // Analog side
  input wire logic [2:0] level_i,
  input wire logic [afc_pkg::SEL_W-1:0] sel_i,
  // Toward the block
  output logic osc_o,
  output logic comp_o
);
  int unsigned cnt_r = 0;
  logic osc_r = 1'b0;
  // The external clock runs free with a period of six core cycles.
  always @(posedge clock_i) begin
    cnt_r <= (cnt_r == 2) ? 0 : cnt_r + 1;
    if (cnt_r == 2) begin
      osc_r <= ~osc_r;
    end
  end
  assign osc_o = osc_r;
  // The comparator trips when the selected input lies above the bandgap level.
  assign comp_o = (sel_i < 3) ? level_i[sel_i] : level_i[0];
endmodule : afc_sense_model

/* tb/testbench.sv */
// Self-checking bench for the analog front-end control block.
// Assumes the sensor model supplies the oscillator and comparator levels.
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ctrl_first_we_i = 1'b0;
  logic ctrl_second_we_i = 1'b0;
  logic dac_we_i = 1'b0;
  logic idle_req_i = 1'b0;
  logic irq_pending_i = 1'b0;
  logic capture_sel_i = 1'b0;
  logic [7:0] ctrl_first_wdata_i = 8'h00;
  logic [2:0] ctrl_second_wdata_i = 3'h0;
  logic [7:0] dac_wdata_i = 8'h00;
  logic [2:0] lvl = 3'h0;
  logic crystal_input_i, comp_raw_i, regulator_on_o, bias_supply_pin_en_o, source_supply_pin_en_o;
  logic ramp_pulldown_pin_en_o, switched_dac_output_pin_en_o, dac_enable_o, cpu_clk_en_o, periph_clk_en_o;
  logic idle_o, irq_wake_o, capture_trig_o;
  logic [7:0] fixed_dac_output_pin_o, analog_control_first_o, d;
  logic [2:0] comparator_input_select_o, analog_control_second_o;
  logic [7:0] corner [3] = '{8'hFF, 8'h7A, 8'h02};
  int bad_count = 0;
  int compares = 0;
  int i, n_cap, n_cpu, n_per;
  wire [7:0] sw = {3'h0, ramp_pulldown_pin_en_o, switched_dac_output_pin_en_o, source_supply_pin_en_o,
                   bias_supply_pin_en_o, regulator_on_o};

  always #5 clock_i = ~clock_i;

  afc_top i_afc_top (.clock_i, .arst_n_i, .crystal_input_i, .ctrl_first_we_i, .ctrl_first_wdata_i,
    .ctrl_second_we_i, .ctrl_second_wdata_i, .dac_we_i, .dac_wdata_i, .idle_req_i, .irq_pending_i,
    .comp_raw_i, .capture_sel_i, .regulator_on_o, .bias_supply_pin_en_o, .source_supply_pin_en_o,
    .ramp_pulldown_pin_en_o, .fixed_dac_output_pin_o, .switched_dac_output_pin_en_o, .dac_enable_o,
    .comparator_input_select_o, .cpu_clk_en_o, .periph_clk_en_o, .idle_o, .irq_wake_o, .capture_trig_o,
    .analog_control_first_o, .analog_control_second_o);

  afc_sense_model i_afc_sense_model (.clock_i, .level_i(lvl), .sel_i(comparator_input_select_o),
    .osc_o(crystal_input_i), .comp_o(comp_raw_i));

  function automatic logic [7:0] exp_sw(input logic [7:0] v, input logic idl);
    return {3'h0, v[5], v[6] & v[1] & ~idl, v[4] & v[1], v[3] & v[1], v[1]};
  endfunction : exp_sw

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Strobe 0 writes the first control register, 1 the select, 2 the DAC code.
  task automatic wr(input int k, input logic [7:0] v);
    @(negedge clock_i);
    {dac_we_i, ctrl_second_we_i, ctrl_first_we_i} = 3'(1 << k);
    ctrl_first_wdata_i = v;
    ctrl_second_wdata_i = v[2:0];
    dac_wdata_i = v;
    @(negedge clock_i);
    {dac_we_i, ctrl_second_we_i, ctrl_first_we_i} = 3'h0;
    repeat (3) @(negedge clock_i);
  endtask : wr

  task automatic win(input int n);
    n_cap = 0;
    n_cpu = 0;
    n_per = 0;
    repeat (5) @(negedge clock_i);
    repeat (n) begin
      @(negedge clock_i);
      n_cap += capture_trig_o;
      n_cpu += cpu_clk_en_o;
      n_per += periph_clk_en_o;
    end
  endtask : win

  task automatic to_idle;
    idle_req_i = 1'b1;
    @(negedge clock_i);
    idle_req_i = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask : to_idle

  initial begin
    void'($urandom(2));
    repeat (4) @(negedge clock_i);
    chk(sw, 8'h00);
    chk({5'h0, analog_control_second_o}, 8'h00);
    arst_n_i = 1'b1;
    @(negedge clock_i);
    for (i = 0; i < 27; i++) begin
      d = (i < 3) ? corner[i] : 8'($urandom);
      wr(0, d);
      chk(analog_control_first_o, d);
      chk(sw, exp_sw(d, 1'b0));
      wr(2, ~d);
      chk(fixed_dac_output_pin_o, ~d);
    end
    for (i = 0; i < 8; i++) begin
      wr(1, 8'(i));
      chk({5'h0, comparator_input_select_o}, (i < 3) ? 8'(i) : 8'h00);
      chk({5'h0, analog_control_second_o}, 8'(i));
    end
    win(120);
    chk(8'(n_per >= 9 && n_per <= 11), 8'h01);
    chk(8'(n_cpu), 8'(n_per));
    capture_sel_i = 1'b1;
    lvl = 3'b110;
    win(40);
    chk(8'(n_cap), 8'h00);
    lvl = 3'b001;
    win(40);
    chk(8'(n_cap > 0), 8'h01);
    // Only the selected input may reach the comparator.
    wr(1, 8'h01);
    lvl = 3'b101;
    win(40);
    chk(8'(n_cap), 8'h00);
    wr(1, 8'h02);
    win(40);
    chk(8'(n_cap > 0), 8'h01);
    capture_sel_i = 1'b0;
    win(40);
    chk(8'(n_cap), 8'h00);
    wr(0, 8'h42);
    chk(sw, exp_sw(8'h42, 1'b0));
    to_idle();
    chk({6'h0, idle_o, dac_enable_o}, 8'h02);
    chk(sw, exp_sw(8'h42, 1'b1));
    win(60);
    chk(8'(n_cpu), 8'h00);
    chk(8'(n_per > 0), 8'h01);
    wr(0, 8'h00);
    chk(analog_control_first_o, 8'h42);
    wr(2, d);
    chk(fixed_dac_output_pin_o, ~d);
    irq_pending_i = 1'b1;
    for (i = 0; i < 8 && irq_wake_o !== 1'b1; i++) @(negedge clock_i);
    chk(8'(irq_wake_o), 8'h01);
    if (i == 8) results();
    for (i = 0; i < 8 && idle_o !== 1'b0; i++) @(negedge clock_i);
    chk(8'(idle_o), 8'h00);
    if (i == 8) results();
    chk(8'(irq_wake_o), 8'h00);
    // An idle request is refused while an interrupt is pending.
    to_idle();
    chk(8'(idle_o), 8'h00);
    irq_pending_i = 1'b0;
    // Analog references settle before the next DAC code is used.
    repeat (20) @(negedge clock_i);
    chk(sw, exp_sw(8'h42, 1'b0));
    wr(0, 8'hFF);
    to_idle();
    chk(8'(idle_o), 8'h01);
    arst_n_i = 1'b0;
    @(negedge clock_i);
    arst_n_i = 1'b1;
    @(negedge clock_i);
    chk({idle_o, sw[6:0]}, 8'h00);
    chk(analog_control_first_o, 8'h00);
    results();
  end
endmodule : testbench
